// [rtl/ard_decoder.sv]
// Aperture register decoder: maps host memory and I/O cycles onto register
// blocks, the draw-engine command queue and the initialization ROM window.
// Assumes host bus and register port share the clock clk; only
// the strap pins come from outside and are synchronised.
//
// Overview of operation
// - Registers are 32-bit; palette group byte-addressed.
// - Sparse I/O base 2ECh, or 1C8h/1CCh.
// - Block I/O base programmable, PCI only.
// - Indices 00h-3Fh direct, also I/O aliased.
// - Draw-engine indices 40h-FFh, memory only.
// - Draw-engine writes queued; reads go direct.
// - Up to 32768 contexts of 64 dwords.
// - 15-bit context pointer locates context segment.
// - Exactly one aperture mode must be enabled.
// - Blocks sit relative to aperture top.
// - Linear aperture fixed 8MB at base.
// - Aperture config register read-only, reports base.
// - Linear blocks at 7FFC00 and 7FF800.
// - VGA blocks at BFC00 and BF800.
// - ROM window only when VGA disabled.
// - ROM strap-placed; low fixed, high paged.
// - Address equals base, block offset, four-times index.
// - Unnumbered offsets belong to block 0.
// - Engine registers memory only; other block 0 registers also I/O.
// - VGA registers are never claimed here.
// - Sparse: low ten bits base, six select.
// - Block I/O: base plus four times select.
// - Block 1 never reachable through I/O.
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps

module ard_decoder
    import ard_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic sys_rst,
    // Strap pins, asynchronous to clk.
    input wire logic [1:0] strap_io_sel,
    input wire logic [4:0] strap_rom_sel,
    input wire logic strap_pci,
    // Host bus cycle to decode.
    input wire ard_hreq_s host_req,
    // Decode result, one cycle after the request.
    output ard_dec_s host_dec,
    // Context load request towards the context loader.
    output logic ctx_load,
    output logic [22:0] ctx_addr,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);

    ////////////////////////////////////////////////////////////////////////
    // State of the block, held as one packed record.
    typedef struct packed {
        logic [1:0] io_sel_meta;   // First strap synchroniser stage.
        logic [1:0] io_sel_sync;   // Second strap synchroniser stage.
        logic [4:0] rom_sel_meta;
        logic [4:0] rom_sel_sync;
        logic pci_meta;
        logic pci_sync;
        logic [1:0] strap_cnt;     // Cycles since reset release.
        logic strap_done;          // Straps have been captured.
        logic [1:0] io_sel;        // Captured sparse base select.
        logic [4:0] rom_sel;       // Captured ROM position select.
        logic pci_mode;            // Captured bus type, 1 is PCI.
        logic lin_en;              // Linear aperture enable.
        logic vga_en;              // VGA section enable.
        logic bio_en;              // Block I/O enable.
        logic rom_en;              // ROM window enable.
        logic [3:0] rom_page;      // Page of the upper ROM half.
        logic [7:0] lin_base;      // Linear base, address bits 31:24.
        logic [15:0] bio_base;     // Block I/O base.
        logic [14:0] ctx_ptr;      // Context load pointer.
        logic ctx_load;            // One-cycle context load pulse.
        logic [22:0] ctx_addr;     // Byte address of the segment.
        logic [31:0] rdata;        // Register read data.
        ard_dec_s dec;             // Registered decode result.
    } ard_state_s;

    ard_state_s state_ff;
    ard_state_s nxt_state;

    // Decode helpers, filled by the combinational process.
    logic mode_ok;
    logic [9:0] io_base;
    logic [15:0] bio_off;
    logic [19:0] rom_base;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic: straps, register port and the address decoder.
    always_comb begin
        nxt_state = state_ff;

        // Exactly one aperture mode must be on.
        mode_ok = state_ff.lin_en ^ state_ff.vga_en;

        // Strap synchronisers; only the second stage is read below.
        nxt_state.io_sel_meta = strap_io_sel;
        nxt_state.io_sel_sync = state_ff.io_sel_meta;
        nxt_state.rom_sel_meta = strap_rom_sel;
        nxt_state.rom_sel_sync = state_ff.rom_sel_meta;
        nxt_state.pci_meta = strap_pci;
        nxt_state.pci_sync = state_ff.pci_meta;

        // Capture straps once the synchronisers hold settled values.
        if (!state_ff.strap_done) begin
            if (state_ff.strap_cnt == ARD_STRAP_WAIT) begin
                nxt_state.strap_done = 1'b1;
                nxt_state.io_sel = state_ff.io_sel_sync;
                nxt_state.rom_sel = state_ff.rom_sel_sync;
                nxt_state.pci_mode = state_ff.pci_sync;
            end else begin
                nxt_state.strap_cnt = state_ff.strap_cnt + 2'h1;
            end
        end

        // Register writes; the aperture config and status are read-only.
        nxt_state.ctx_load = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                ARD_OFF_CTRL: begin
                    nxt_state.lin_en = reg_wdata[ARD_CTRL_LIN_EN];
                    nxt_state.vga_en = reg_wdata[ARD_CTRL_VGA_EN];
                    nxt_state.bio_en = reg_wdata[ARD_CTRL_BIO_EN];
                    nxt_state.rom_en = reg_wdata[ARD_CTRL_ROM_EN];
                    nxt_state.rom_page =
                        reg_wdata[ARD_CTRL_PAGE_LSB +: 4];
                end
                ARD_OFF_LIN_BASE: begin
                    // Only bits 31:24 are kept; the host aligns to 16MB.
                    nxt_state.lin_base = reg_wdata[31:24];
                end
                ARD_OFF_BIO_BASE: begin
                    nxt_state.bio_base = reg_wdata[15:0];
                end
                ARD_OFF_CTX_PTR: begin
                    // A pointer write starts one context load.
                    nxt_state.ctx_ptr = reg_wdata[14:0];
                    nxt_state.ctx_load = 1'b1;
                    nxt_state.ctx_addr =
                        23'(reg_wdata[14:0]) << ARD_CTX_SHIFT;
                end
                default: begin
                    // Read-only or unmapped: the write is dropped.
                end
            endcase
        end

        // Register reads answer in the next cycle; unmapped reads zero.
        nxt_state.rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                ARD_OFF_CTRL: begin
                    nxt_state.rdata[ARD_CTRL_LIN_EN] = state_ff.lin_en;
                    nxt_state.rdata[ARD_CTRL_VGA_EN] = state_ff.vga_en;
                    nxt_state.rdata[ARD_CTRL_BIO_EN] = state_ff.bio_en;
                    nxt_state.rdata[ARD_CTRL_ROM_EN] = state_ff.rom_en;
                    nxt_state.rdata[ARD_CTRL_PAGE_LSB +: 4] =
                        state_ff.rom_page;
                end
                ARD_OFF_LIN_BASE: begin
                    nxt_state.rdata[31:24] = state_ff.lin_base;
                end
                ARD_OFF_BIO_BASE: begin
                    nxt_state.rdata[15:0] = state_ff.bio_base;
                end
                ARD_OFF_CTX_PTR: begin
                    nxt_state.rdata[14:0] = state_ff.ctx_ptr;
                end
                ARD_OFF_APER_CFG: begin
                    // Linear position and size, live enable.
                    nxt_state.rdata[31:24] = state_ff.lin_base;
                    nxt_state.rdata[15:8] = ARD_LIN_SIZE_MB;
                    nxt_state.rdata[0] = state_ff.lin_en;
                end
                ARD_OFF_STATUS: begin
                    nxt_state.rdata[1:0] = state_ff.io_sel;
                    nxt_state.rdata[8:4] = state_ff.rom_sel;
                    nxt_state.rdata[12] = state_ff.pci_mode;
                    nxt_state.rdata[16] = mode_ok;
                    nxt_state.rdata[20] = state_ff.strap_done;
                end
                default: begin
                    nxt_state.rdata = 32'h0000_0000;
                end
            endcase
        end

        // Sparse I/O base from the strap.
        case (state_ff.io_sel)
            2'h1: io_base = ARD_IO_BASE_ALT0;
            2'h2: io_base = ARD_IO_BASE_ALT1;
            default: io_base = ARD_IO_BASE_STD;
        endcase

        // Block I/O offset from the programmed base.
        bio_off = host_req.addr[15:0] - state_ff.bio_base;

        // ROM window base, one 8KB step per strap code.
        rom_base = ARD_ROM_FIRST + 20'(state_ff.rom_sel * ARD_ROM_STEP);

        // Default: nothing claimed. Byte lanes pass through.
        nxt_state.dec.hit = 1'b0;
        nxt_state.dec.tgt = ARD_TGT_NONE;
        nxt_state.dec.block1 = 1'b0;
        nxt_state.dec.sparse = 1'b0;
        nxt_state.dec.idx = host_req.addr[9:2];
        nxt_state.dec.be = host_req.be;
        nxt_state.dec.wr = host_req.wr;
        nxt_state.dec.fifo_push = 1'b0;
        nxt_state.dec.direct_rd = 1'b0;
        nxt_state.dec.rom_addr = 15'h0000;

        if (host_req.valid && host_req.io && state_ff.strap_done) begin
            // I/O space reaches block 0 setup registers only.
            // Fixed VGA ports are left to the VGA section.
            if (state_ff.bio_en && state_ff.pci_mode) begin
                if (bio_off < ARD_BIO_SPAN) begin
                    nxt_state.dec.hit = 1'b1;
                    nxt_state.dec.tgt = ARD_TGT_SETUP;
                    nxt_state.dec.idx = bio_off[9:2];
                end
            end else if (host_req.addr[9:2] == io_base[9:2]) begin
                // Address bits 9:2 match the base, six bits select.
                nxt_state.dec.hit = 1'b1;
                nxt_state.dec.tgt = ARD_TGT_SETUP;
                nxt_state.dec.sparse = 1'b1;
                nxt_state.dec.idx = {2'h0, host_req.addr[15:10]};
            end
        end else if (host_req.valid && !host_req.io) begin
            // Register blocks counted down from the aperture top.
            if (mode_ok && state_ff.lin_en &&
                    host_req.addr[31:24] == state_ff.lin_base &&
                    host_req.addr[23] == 1'b0) begin
                if (host_req.addr[22:10] ==
                        ARD_LIN_BLK0_OFF[22:10]) begin
                    nxt_state.dec.hit = 1'b1;
                end else if (host_req.addr[22:10] ==
                        ARD_LIN_BLK1_OFF[22:10]) begin
                    nxt_state.dec.hit = 1'b1;
                    nxt_state.dec.block1 = 1'b1;
                end
            end else if (mode_ok && state_ff.vga_en &&
                    host_req.addr[31:16] ==
                        {12'h000, ARD_VGA_APER_BASE[19:16]}) begin
                if (host_req.addr[15:10] ==
                        ARD_VGA_BLK0_OFF[15:10]) begin
                    nxt_state.dec.hit = 1'b1;
                end else if (host_req.addr[15:10] ==
                        ARD_VGA_BLK1_OFF[15:10]) begin
                    nxt_state.dec.hit = 1'b1;
                    nxt_state.dec.block1 = 1'b1;
                end
            end else if (!state_ff.vga_en && state_ff.rom_en &&
                    host_req.addr[31:12] ==
                        {12'h000, rom_base[19:12]}) begin
                // Low 2KB fixed, high 2KB from the selected page.
                nxt_state.dec.hit = 1'b1;
                nxt_state.dec.tgt = ARD_TGT_ROM;
                nxt_state.dec.rom_addr = host_req.addr[11] ?
                    {state_ff.rom_page, host_req.addr[10:0]} :
                    {4'h0, host_req.addr[10:0]};
            end

            // Classify a register hit; plain offsets are block 0.
            if (nxt_state.dec.hit && nxt_state.dec.tgt != ARD_TGT_ROM) begin
                if (nxt_state.dec.block1) begin
                    nxt_state.dec.tgt = ARD_TGT_BLK1;
                end else if (host_req.addr[9:2] >= ARD_DE_FIRST_IDX) begin
                    nxt_state.dec.tgt = ARD_TGT_DRAW;
                end else begin
                    nxt_state.dec.tgt = ARD_TGT_SETUP;
                end
            end
        end

        // Draw-engine writes are queued, reads taken directly.
        nxt_state.dec.fifo_push = nxt_state.dec.hit && host_req.wr &&
            nxt_state.dec.tgt == ARD_TGT_DRAW;
        nxt_state.dec.direct_rd = nxt_state.dec.hit && !host_req.wr &&
            nxt_state.dec.tgt != ARD_TGT_ROM;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register with its reset values.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= '0;
            state_ff.lin_en <= ARD_RST_LIN_EN;
            state_ff.vga_en <= ARD_RST_VGA_EN;
            state_ff.bio_en <= ARD_RST_BIO_EN;
            state_ff.rom_en <= ARD_RST_ROM_EN;
            state_ff.rom_page <= ARD_RST_PAGE;
            state_ff.lin_base <= ARD_RST_LIN_BASE;
            state_ff.bio_base <= ARD_RST_BIO_BASE;
            state_ff.ctx_ptr <= ARD_RST_CTX_PTR;
            state_ff.dec.tgt <= ARD_TGT_NONE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Outputs come straight from the state register.
    assign host_dec = state_ff.dec;
    assign ctx_load = state_ff.ctx_load;
    assign ctx_addr = state_ff.ctx_addr;
    assign reg_rdata = state_ff.rdata;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the decoder.
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // A memory register hit needs exactly one mode enabled.
    property p_mode_excl;
        host_dec.hit && host_dec.tgt != ARD_TGT_ROM && !$past(host_req.io)
            |-> $past(state_ff.lin_en) != $past(state_ff.vga_en);
    endproperty
    a_mode_excl: assert property (p_mode_excl)
        else $error("register hit without exactly one mode");

    // Linear block 0 at the top 1KB of the aperture.
    property p_lin_blk0;
        host_req.valid && !host_req.io && state_ff.lin_en &&
            !state_ff.vga_en && host_req.addr[31:24] == state_ff.lin_base &&
            host_req.addr[23:10] == 14'h1fff
            |=> host_dec.hit && !host_dec.block1;
    endproperty
    a_lin_blk0: assert property (p_lin_blk0)
        else $error("linear block 0 not decoded");

    // VGA block 1 just below block 0.
    property p_vga_blk1;
        host_req.valid && !host_req.io && state_ff.vga_en &&
            !state_ff.lin_en && host_req.addr[31:10] == 22'h0002fe
            |=> host_dec.hit && host_dec.block1 &&
                host_dec.tgt == ARD_TGT_BLK1;
    endproperty
    a_vga_blk1: assert property (p_vga_blk1)
        else $error("VGA block 1 not decoded");

    // Draw-engine writes go to the queue, never a direct read.
    property p_draw_queue;
        host_dec.hit && host_dec.tgt == ARD_TGT_DRAW
            |-> host_dec.fifo_push == host_dec.wr &&
                host_dec.direct_rd == !host_dec.wr &&
                host_dec.idx >= ARD_DE_FIRST_IDX;
    endproperty
    a_draw_queue: assert property (p_draw_queue)
        else $error("draw-engine access routed wrongly");

    // I/O cycles never reach block 1 or the draw engine.
    property p_io_blk0;
        host_dec.hit && $past(host_req.io)
            |-> host_dec.tgt == ARD_TGT_SETUP && !host_dec.block1 &&
                host_dec.idx < ARD_DE_FIRST_IDX;
    endproperty
    a_io_blk0: assert property (p_io_blk0)
        else $error("I/O cycle reached a memory-only register");

    // Sparse hits carry the six select bits as index.
    property p_sparse;
        host_dec.hit && host_dec.sparse
            |-> host_dec.idx == {2'h0, $past(host_req.addr[15:10])} &&
                $past(host_req.addr[9:2]) == $past(io_base[9:2]);
    endproperty
    a_sparse: assert property (p_sparse)
        else $error("sparse I/O decode wrong");

    // A pointer write gives one load pulse with the segment address.
    property p_ctx;
        reg_wr && reg_addr == ARD_OFF_CTX_PTR
            |=> ctx_load && ctx_addr == {$past(reg_wdata[14:0]), 8'h00}
                ##1 ctx_load == $past(reg_wr && reg_addr == ARD_OFF_CTX_PTR);
    endproperty
    a_ctx: assert property (p_ctx)
        else $error("context load pulse or address wrong");

    // ROM hits only while the VGA section is off.
    property p_rom_vga;
        host_dec.tgt == ARD_TGT_ROM |-> !$past(state_ff.vga_en);
    endproperty
    a_rom_vga: assert property (p_rom_vga)
        else $error("ROM window decoded with VGA on");

    // The aperture config register ignores writes.
    property p_cfg_ro;
        reg_wr && reg_addr == ARD_OFF_APER_CFG
            |=> state_ff.lin_base == $past(state_ff.lin_base) &&
                state_ff.lin_en == $past(state_ff.lin_en);
    endproperty
    a_cfg_ro: assert property (p_cfg_ro)
        else $error("aperture config register changed by a write");

    // Main scenarios.
    c_draw_write: cover property (host_dec.fifo_push);
    c_blk1_read: cover property (host_dec.direct_rd && host_dec.block1);
    c_sparse_hit: cover property (host_dec.hit && host_dec.sparse);
    c_rom_page: cover property (host_dec.tgt == ARD_TGT_ROM &&
        host_dec.rom_addr[14:11] != 4'h0);

endmodule : ard_decoder

// [rtl/ard_pkg.sv]
// Package for the aperture register decoder: offsets, fields, reset values,
// aperture geometry and the carrier types.
// Assumes one clock domain shared by the host bus and the register port.
package ard_pkg;

    // Register port byte offsets, one aligned 32-bit word each.
    localparam logic [7:0] ARD_OFF_CTRL = 8'h00;
    localparam logic [7:0] ARD_OFF_LIN_BASE = 8'h04;
    localparam logic [7:0] ARD_OFF_BIO_BASE = 8'h08;
    localparam logic [7:0] ARD_OFF_CTX_PTR = 8'h0c;
    localparam logic [7:0] ARD_OFF_APER_CFG = 8'h10;
    localparam logic [7:0] ARD_OFF_STATUS = 8'h14;

    // Control register field positions.
    localparam int ARD_CTRL_LIN_EN = 0;
    localparam int ARD_CTRL_VGA_EN = 1;
    localparam int ARD_CTRL_BIO_EN = 2;
    localparam int ARD_CTRL_ROM_EN = 3;
    localparam int ARD_CTRL_PAGE_LSB = 4;

    // Reset values: VGA aperture on, everything else off.
    localparam logic ARD_RST_LIN_EN = 1'h0;
    localparam logic ARD_RST_VGA_EN = 1'h1;
    localparam logic ARD_RST_BIO_EN = 1'h0;
    localparam logic ARD_RST_ROM_EN = 1'h0;
    localparam logic [3:0] ARD_RST_PAGE = 4'h0;
    localparam logic [7:0] ARD_RST_LIN_BASE = 8'h00;
    localparam logic [15:0] ARD_RST_BIO_BASE = 16'h0000;
    localparam logic [14:0] ARD_RST_CTX_PTR = 15'h0000;

    // Aperture geometry (offsets within the aperture).
    localparam logic [22:0] ARD_LIN_BLK0_OFF = 23'h7ffc00;
    localparam logic [22:0] ARD_LIN_BLK1_OFF = 23'h7ff800;
    localparam logic [7:0] ARD_LIN_SIZE_MB = 8'h08;
    localparam logic [19:0] ARD_VGA_APER_BASE = 20'hb0000;
    localparam logic [19:0] ARD_VGA_BLK0_OFF = 20'hbfc00;
    localparam logic [19:0] ARD_VGA_BLK1_OFF = 20'hbf800;
    localparam logic [7:0] ARD_DE_FIRST_IDX = 8'h40;

    // I/O bases and spans.
    localparam logic [9:0] ARD_IO_BASE_STD = 10'h2ec;
    localparam logic [9:0] ARD_IO_BASE_ALT0 = 10'h1c8;
    localparam logic [9:0] ARD_IO_BASE_ALT1 = 10'h1cc;
    localparam logic [15:0] ARD_BIO_SPAN = 16'h0100;

    // Initialization ROM window.
    localparam logic [19:0] ARD_ROM_FIRST = 20'hc0000;
    localparam logic [19:0] ARD_ROM_STEP = 20'h02000;

    // Context segment is 64 dwords, so the byte address is pointer << 8.
    localparam int ARD_CTX_SHIFT = 8;

    // Straps are taken on the edge after strap_cnt reaches this count, one cycle more than this after reset release.
    localparam logic [1:0] ARD_STRAP_WAIT = 2'h2;

    // Decode target, one-hot.
    typedef enum logic [4:0] {
        ARD_TGT_NONE = 5'b00001,
        ARD_TGT_SETUP = 5'b00010,
        ARD_TGT_DRAW = 5'b00100,
        ARD_TGT_BLK1 = 5'b01000,
        ARD_TGT_ROM = 5'b10000
    } ard_tgt_e;

    // One host bus cycle as seen by the decoder.
    typedef struct packed {
        logic valid;
        logic io;
        logic wr;
        logic [31:0] addr;
        logic [3:0] be;
    } ard_hreq_s;

    // Decode result for one host cycle.
    typedef struct packed {
        logic hit;
        ard_tgt_e tgt;
        logic block1;
        logic sparse;
        logic [7:0] idx;
        logic [3:0] be;
        logic wr;
        logic fifo_push;
        logic direct_rd;
        logic [14:0] rom_addr;
    } ard_dec_s;

endpackage : ard_pkg

// [tb/ard_host_model.sv]
// Host bus master model: issues one memory or I/O cycle at a time.
// Assumes it shares clk with the decoder and drives on the rising edge.
`timescale 1ns/1ps

module ard_host_model
    import ard_pkg::*;
(
    // Clock.
    input wire logic clk,
    // Host cycle towards the decoder.
    output ard_hreq_s req
);
    initial req = '0;

    // One cycle: request held over one edge, then released.
    task automatic cyc(input logic io, input logic wr, input logic [31:0] a);
        @(posedge clk);
        req <= '{valid: 1'b1, io: io, wr: wr, addr: a, be: 4'hf};
        @(posedge clk);
        // Released address is inverted so stale values never match.
        req <= '{valid: 1'b0, io: io, wr: 1'b0, addr: ~a, be: 4'h0};
    endtask : cyc
endmodule : ard_host_model

// [tb/tb.sv]
// Testbench for the aperture register decoder.
// Assumes the host model drives host cycles; straps start at PCI, base
// 2ECh, and are changed across mid-run resets.
`timescale 1ns/1ps

module tb;
    import ard_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    ard_hreq_s hreq;
    ard_dec_s dec;
    logic ctx_load;
    logic [22:0] ctx_addr;
    logic [7:0] ra = 8'h00;
    logic [31:0] wd = 32'h0;
    logic rw = 1'b0;
    logic rr = 1'b0;
    logic [31:0] rd;
    int bad_count = 0;
    int n_tests = 0;
    int cyc_n = 0;
    logic [1:0] strap_io = 2'h0;
    logic [4:0] strap_rom = 5'h00;

    ard_host_model ard_host_model_inst (.clk(clk), .req(hreq));
    ard_decoder ard_decoder_inst (.clk(clk), .sys_rst(sys_rst),
        .strap_io_sel(strap_io), .strap_rom_sel(strap_rom), .strap_pci(1'b1),
        .host_req(hreq), .host_dec(dec), .ctx_load(ctx_load),
        .ctx_addr(ctx_addr), .reg_addr(ra), .reg_wdata(wd), .reg_wr(rw),
        .reg_rd(rr), .reg_rdata(rd));

    // 40 MHz clock and a bounded run.
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 3000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk32

    // Host cycle, then the decode result in the following cycle.
    task automatic chk_dec(input logic io, input logic wr,
        input logic [31:0] a, input logic h, input ard_tgt_e t,
        input logic [7:0] i);
        ard_host_model_inst.cyc(io, wr, a);
        #1;
        n_tests++;
        if (dec.hit !== h || (h && (dec.tgt !== t || dec.idx !== i))) begin
            bad_count++;
            $display("wrong value at %0t: decode of %h", $time, a);
        end
    endtask : chk_dec

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        ra <= a;
        wd <= d;
        rw <= 1'b1;
        @(posedge clk);
        rw <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        ra <= a;
        rr <= 1'b1;
        @(posedge clk);
        rr <= 1'b0;
        #1 chk32(rd, exp);
    endtask : rd_reg

    // Mid-run reset with new strap levels, then wait for strap capture.
    task automatic restart(input logic [1:0] s_io, input logic [4:0] s_rom);
        @(posedge clk);
        sys_rst <= 1'b1;
        strap_io <= s_io;
        strap_rom <= s_rom;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (5) @(posedge clk);
    endtask : restart

    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (5) @(posedge clk);
        rd_reg(8'h00, 32'h00000002);
        rd_reg(8'h10, 32'h00000800);
        wr_reg(8'h10, 32'hffffffff);
        rd_reg(8'h10, 32'h00000800);
        rd_reg(8'h20, 32'h00000000);
        $display("test reset and read-only done");
        chk_dec(0, 0, 32'hbfc14, 1, ARD_TGT_SETUP, 8'h05);
        chk_dec(0, 0, 32'hbf824, 1, ARD_TGT_BLK1, 8'h09);
        chk32({31'h0, dec.block1}, 32'h1);
        chk_dec(0, 1, 32'hbfd00, 1, ARD_TGT_DRAW, 8'h40);
        chk32({30'h0, dec.fifo_push, dec.direct_rd}, 32'h2);
        chk_dec(0, 0, 32'hbfffc, 1, ARD_TGT_DRAW, 8'hff);
        chk32({30'h0, dec.fifo_push, dec.direct_rd}, 32'h1);
        chk_dec(1, 0, 32'h46ec, 1, ARD_TGT_SETUP, 8'h11);
        chk_dec(1, 0, 32'h45c8, 0, ARD_TGT_NONE, 8'h00);
        $display("test VGA aperture done");
        wr_reg(8'h04, 32'h01000000);
        wr_reg(8'h00, 32'h00000001);
        rd_reg(8'h10, 32'h01000801);
        chk_dec(0, 1, 32'h017ffd00, 1, ARD_TGT_DRAW, 8'h40);
        chk_dec(0, 0, 32'h017ff824, 1, ARD_TGT_BLK1, 8'h09);
        chk_dec(0, 0, 32'h000bfc14, 0, ARD_TGT_NONE, 8'h00);
        wr_reg(8'h00, 32'h00000003);
        chk_dec(0, 0, 32'h017ffc14, 0, ARD_TGT_NONE, 8'h00);
        $display("test linear aperture done");
        wr_reg(8'h08, 32'h0000e000);
        wr_reg(8'h00, 32'h00000006);
        chk_dec(1, 0, 32'he084, 1, ARD_TGT_SETUP, 8'h21);
        chk32({31'h0, dec.sparse}, 32'h0);
        chk32({28'h0, dec.be}, 32'hf);
        wr_reg(8'h0c, 32'h00007fff);
        #1 chk32({8'h0, ctx_load, ctx_addr}, 32'h00ffff00);
        $display("test block I/O and context done");
        restart(2'h2, 5'h00);
        chk_dec(1, 0, 32'h45cc, 1, ARD_TGT_SETUP, 8'h11);
        chk_dec(1, 0, 32'h46ec, 0, ARD_TGT_NONE, 8'h00);
        restart(2'h1, 5'h03);
        rd_reg(8'h14, 32'h00111031);
        chk_dec(1, 0, 32'h45c8, 1, ARD_TGT_SETUP, 8'h11);
        wr_reg(8'h00, 32'h0000005a);
        chk_dec(0, 0, 32'h000c6804, 0, ARD_TGT_NONE, 8'h00);
        wr_reg(8'h00, 32'h00000058);
        chk_dec(0, 0, 32'h000c6804, 1, ARD_TGT_ROM, 8'h01);
        chk32({17'h0, dec.rom_addr}, 32'h00002804);
        chk32({30'h0, dec.fifo_push, dec.direct_rd}, 32'h0);
        chk_dec(0, 0, 32'h000c6004, 1, ARD_TGT_ROM, 8'h01);
        chk32({17'h0, dec.rom_addr}, 32'h00000004);
        $display("test straps and ROM window done");
        report_and_stop();
    end
endmodule : tb
